// >>> rtl/zpa_zero_ctrl.sv
`timescale 1ns/1ps
`default_nettype none
`include "zpa_map.svh"
module zpa_zero_ctrl (
  // clock and reset
  input  wire logic        clk_sys,
  input  wire logic        rst,
  // command byte stream
  input  wire logic        rxValid,
  input  wire logic [7:0]  rxData,
  output logic             txValid,
  output logic [7:0]       txData,
  input  wire logic        txReady,
  // auto-zero timer event and state
  input  wire logic        autoZeroEvt,
  output logic             autoZeroOn,
  // axi4-lite slave
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready
);
  import zpa_pkg::*;

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);

  // ==========================================================
  // state
  zpa_line_t     cmd;
  zpa_tx_state_t txStQ;
  logic          lineDone, rawQ, sleep;
  logic [15:0]   zeroQ, freshQ, bgQ, measQ, newZero, mult;
  logic [15:0]   azInitQ, azRegQ, repNum0Q, repNum1Q;
  logic [1:0]    ctrlQ;
  logic [7:0]    refusedQ, repLetterQ, curChar;
  logic [7:0]    lineBuf [16];
  logic [7:0]    azLine [16];
  logic [4:0]    lineLenQ, lastLenQ, azLenQ, idxQ, lenQ;
  logic          isFine, isFresh, isNitro, isManual, isKnown;
  logic          isParam, isAz, isAzSet, isMult;
  logic          alters, accept, startTx;

  // ==========================================================
  // helpers
  function automatic logic [7:0] decChar(input logic [15:0] v,
                                         input logic [2:0]  pos);
    logic [15:0] q;
    case (pos)
      3'h0:    q = v / 16'h2710;
      3'h1:    q = v / 16'h03E8;
      3'h2:    q = v / 16'h0064;
      3'h3:    q = v / 16'h000A;
      default: q = v;
    endcase
    decChar = `ZPA_CH_0 + {4'h0, 4'(q % 16'h000A)};
  endfunction : decChar
  // ==========================================================
  // command decode
  assign sleep    = ctrlQ[`ZPA_CTRL_SLEEP];
  assign mult     = ctrlQ[`ZPA_CTRL_WIDE] ? `ZPA_MULT_HIGH
                                          : `ZPA_MULT_LOW;
  assign isFine   = cmd.letter == `ZPA_CMD_FINE   && cmd.nargs == 2'h2;
  assign isFresh  = cmd.letter == `ZPA_CMD_FRESH  && cmd.nargs == 2'h0;
  assign isNitro  = cmd.letter == `ZPA_CMD_NITRO  && cmd.nargs == 2'h0;
  assign isManual = cmd.letter == `ZPA_CMD_MANUAL && cmd.nargs == 2'h1;
  assign isKnown  = cmd.letter == `ZPA_CMD_KNOWN  && cmd.nargs == 2'h1;
  assign isParam  = cmd.letter == `ZPA_CMD_PARAM  && cmd.nargs == 2'h2;
  assign isAz     = cmd.letter == `ZPA_CH_AT;
  assign isAzSet  = isAz && (cmd.nargs == 2'h2 ||
                    (cmd.nargs == 2'h1 && cmd.arg0 == 16'h0000));
  assign isMult   = cmd.letter == `ZPA_CMD_MULT   && cmd.nargs == 2'h0;
  assign alters   = isFine | isFresh | isNitro | isManual | isKnown |
                    isParam | isAzSet;
  // a line arriving while a reply is still going out is dropped
  assign accept   = lineDone && txStQ == ZPA_TX_IDLE &&
                    !(alters && sleep);
  assign startTx  = accept && (alters || isMult ||
                    (isAz && cmd.nargs == 2'h0));
  // arguments arrive pre-scaled, so zero math wraps at 16 bits
  always_comb begin
    newZero = zeroQ;
    if (isFine)   newZero = zeroQ + cmd.arg0 - cmd.arg1;
    if (isFresh)  newZero = zeroQ + measQ - freshQ;
    if (isNitro)  newZero = zeroQ + measQ;
    if (isManual) newZero = cmd.arg0;
    if (isKnown)  newZero = zeroQ + measQ - cmd.arg0;
  end

  // ==========================================================
  // zero point and stored parameters
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      zeroQ <= `ZPA_ZERO_RESET;
    end else if (accept && alters) begin
      zeroQ <= newZero;
    end else if (autoZeroEvt && autoZeroOn && !sleep && !lineDone) begin
      zeroQ <= zeroQ + measQ - bgQ;
    end
  end
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      bgQ    <= `ZPA_CONC_RESET;
      freshQ <= `ZPA_CONC_RESET;
    end else if (accept && isParam) begin
      case (cmd.arg0)
        `ZPA_PIDX_BG_HI: bgQ[15:8]    <= cmd.arg1[7:0];
        `ZPA_PIDX_BG_LO: bgQ[7:0]     <= cmd.arg1[7:0];
        `ZPA_PIDX_FA_HI: freshQ[15:8] <= cmd.arg1[7:0];
        `ZPA_PIDX_FA_LO: freshQ[7:0]  <= cmd.arg1[7:0];
        default:         bgQ          <= bgQ;
      endcase
    end
  end

  // ==========================================================
  // auto-zero intervals, kept in tenths of a day
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      azInitQ    <= 16'h0000;
      azRegQ     <= 16'h0000;
      autoZeroOn <= 1'b0;
    end else if (accept && isAzSet) begin
      azInitQ    <= (cmd.nargs == 2'h2) ? cmd.arg0 : 16'h0000;
      azRegQ     <= (cmd.nargs == 2'h2) ? cmd.arg1 : 16'h0000;
      autoZeroOn <= (cmd.nargs == 2'h2) &&
                    (cmd.arg0 != 16'h0000 || cmd.arg1 != 16'h0000);
    end
  end

  // raw bytes of the line so an interval set echoes verbatim
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      lineLenQ <= 5'h00;
      lastLenQ <= 5'h00;
      for (int i = 0; i < 16; i++) lineBuf[i] <= 8'h00;
    end else if (rxValid) begin
      if (rxData == `ZPA_CH_LF) begin
        lastLenQ <= lineLenQ;
        lineLenQ <= 5'h00;
      end else if (rxData != `ZPA_CH_CR && lineLenQ != `ZPA_LINE_MAX) begin
        lineBuf[lineLenQ[3:0]] <= rxData;
        lineLenQ               <= lineLenQ + 5'h01;
      end
    end
  end
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      azLenQ <= 5'h03;
      for (int i = 0; i < 16; i++) azLine[i] <= 8'h00;
      azLine[0] <= `ZPA_CH_AT;
      azLine[1] <= `ZPA_CH_SPACE;
      azLine[2] <= `ZPA_CH_0;
    end else if (accept && isAzSet) begin
      azLenQ <= lastLenQ;
      for (int i = 0; i < 16; i++) azLine[i] <= lineBuf[i];
    end
  end

  // ==========================================================
  // reply transmitter
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      rawQ       <= 1'b0;
      lenQ       <= 5'h00;
      repLetterQ <= 8'h00;
      repNum0Q   <= 16'h0000;
      repNum1Q   <= 16'h0000;
    end else if (startTx) begin
      rawQ       <= isAz;
      lenQ       <= isAz ? 5'((isAzSet ? lastLenQ : azLenQ) + 5'h02)
                         : (isParam ? 5'h0F : 5'h09);
      repLetterQ <= cmd.letter;
      repNum0Q   <= isParam ? cmd.arg0 : (isMult ? mult : newZero);
      repNum1Q   <= cmd.arg1;
    end
  end
  always_comb begin
    logic [4:0] rel;
    rel     = idxQ - 5'h01;
    curChar = `ZPA_CH_LF;
    if (rawQ) begin
      if (idxQ < lenQ - 5'h02) curChar = azLine[idxQ[3:0]];
      else if (idxQ == lenQ - 5'h02) curChar = `ZPA_CH_CR;
    end else if (idxQ == 5'h00) begin
      curChar = repLetterQ;
    end else if (idxQ < lenQ - 5'h02) begin
      if (rel == 5'h00 || rel == 5'h06) curChar = `ZPA_CH_SPACE;
      else if (rel < 5'h06) curChar = decChar(repNum0Q, 3'(rel - 5'h01));
      else curChar = decChar(repNum1Q, 3'(rel - 5'h07));
    end else if (idxQ == lenQ - 5'h02) begin
      curChar = `ZPA_CH_CR;
    end
  end
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      txStQ   <= ZPA_TX_IDLE;
      idxQ    <= 5'h00;
      txValid <= 1'b0;
      txData  <= 8'h00;
    end else begin
      case (txStQ)
        ZPA_TX_IDLE: begin
          idxQ <= 5'h00;
          if (startTx) txStQ <= ZPA_TX_SEND;
        end
        ZPA_TX_SEND: begin
          if (!txValid || txReady) begin
            if (idxQ == lenQ) begin
              txValid <= 1'b0;
              txStQ   <= ZPA_TX_IDLE;
            end else begin
              txData  <= curChar;
              txValid <= 1'b1;
              idxQ    <= idxQ + 5'h01;
            end
          end
        end
        default: txStQ <= ZPA_TX_IDLE;
      endcase
    end
  end

  // ==========================================================
  // refused command count
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) refusedQ <= 8'h00;
    else if (lineDone && alters && sleep) refusedQ <= refusedQ + 8'h01;
  end

  // ==========================================================
  // axi4-lite slave, both write channels taken in one cycle
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= `ZPA_RESP_OKAY;
      ctrlQ         <= 2'h0;
      measQ         <= 16'h0000;
    end else begin
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      if (s_axi_bvalid && s_axi_bready) s_axi_bvalid <= 1'b0;
      if (s_axi_awvalid && s_axi_wvalid && !s_axi_awready && !s_axi_bvalid) begin
        s_axi_awready <= 1'b1;
        s_axi_wready  <= 1'b1;
        s_axi_bvalid  <= 1'b1;
        s_axi_bresp   <= `ZPA_RESP_OKAY;
        case (s_axi_awaddr)
          `ZPA_REG_CTRL: if (s_axi_wstrb[0]) ctrlQ <= s_axi_wdata[1:0];
          `ZPA_REG_MEAS: begin
            if (s_axi_wstrb[0]) measQ[7:0]  <= s_axi_wdata[7:0];
            if (s_axi_wstrb[1]) measQ[15:8] <= s_axi_wdata[15:8];
          end
          `ZPA_REG_ZERO, `ZPA_REG_FRESH, `ZPA_REG_BKGND,
          `ZPA_REG_AZCFG, `ZPA_REG_STATUS: s_axi_bresp <= `ZPA_RESP_OKAY;
          default: s_axi_bresp <= `ZPA_RESP_SLVERR;
        endcase
      end
    end
  end
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h00000000;
      s_axi_rresp   <= `ZPA_RESP_OKAY;
    end else begin
      s_axi_arready <= 1'b0;
      if (s_axi_rvalid && s_axi_rready) s_axi_rvalid <= 1'b0;
      if (s_axi_arvalid && !s_axi_arready && !s_axi_rvalid) begin
        s_axi_arready <= 1'b1;
        s_axi_rvalid  <= 1'b1;
        s_axi_rresp   <= `ZPA_RESP_OKAY;
        s_axi_rdata   <= 32'h00000000;
        case (s_axi_araddr)
          `ZPA_REG_CTRL:   s_axi_rdata <= {30'h00000000, ctrlQ};
          `ZPA_REG_MEAS:   s_axi_rdata <= {16'h0000, measQ};
          `ZPA_REG_ZERO:   s_axi_rdata <= {16'h0000, zeroQ};
          `ZPA_REG_FRESH:  s_axi_rdata <= {16'h0000, freshQ};
          `ZPA_REG_BKGND:  s_axi_rdata <= {16'h0000, bgQ};
          `ZPA_REG_AZCFG:  s_axi_rdata <= {azInitQ, azRegQ};
          `ZPA_REG_STATUS: s_axi_rdata <= {16'h0000, refusedQ, 6'h00,
                                           txStQ == ZPA_TX_SEND, autoZeroOn};
          default:         s_axi_rresp <= `ZPA_RESP_SLVERR;
        endcase
      end
    end
  end

  zpa_line_parser u_parser (
    .clk_sys  (clk_sys),  .rst     (rst),
    .rxValid  (rxValid),  .rxData  (rxData),
    .lineDone (lineDone), .lineOut (cmd)
  );

  // ==========================================================
  // checks
  fine_tune_a : assert property (accept && isFine |=>
    zeroQ == $past(zeroQ) + $past(cmd.arg0) - $past(cmd.arg1))
    else $error("fine tune zero wrong");
  fresh_air_a : assert property (accept && isFresh |=>
    zeroQ == $past(zeroQ) + $past(measQ) - $past(freshQ))
    else $error("fresh air zero wrong");
  nitro_zero_a : assert property (accept && isNitro |=>
    zeroQ == $past(zeroQ) + $past(measQ))
    else $error("nitrogen zero wrong");
  manual_zero_a : assert property (accept && isManual |=>
    zeroQ == $past(cmd.arg0) && repNum0Q == zeroQ)
    else $error("manual zero not forced");
  param_byte_a : assert property (accept && isParam &&
    cmd.arg0 == `ZPA_PIDX_BG_HI |=> bgQ[15:8] == $past(cmd.arg1[7:0]))
    else $error("background high byte not stored");
  sleep_refuse_a : assert property (lineDone && sleep && alters |=>
    $stable(zeroQ) && $stable(bgQ) && $stable(freshQ) && txStQ == ZPA_TX_IDLE)
    else $error("zero setting changed in sleep");
  az_disable_a : assert property (accept && isAzSet &&
    cmd.nargs == 2'h1 |=> !autoZeroOn)
    else $error("auto-zero not disabled");
  reply_head_a : assert property (startTx |-> ##2
    txValid && txData == repLetterQ)
    else $error("reply does not open with letter");
  mult_rep_a : assert property (accept && isMult |=>
    repNum0Q == $past(mult))
    else $error("multiplier reply wrong");
  zero_cmd_c   : cover property (accept && isKnown);
  param_cmd_c  : cover property (accept && isParam);
  az_query_c   : cover property (accept && isAz && cmd.nargs == 2'h0);
  refused_c    : cover property (lineDone && sleep && alters);
endmodule : zpa_zero_ctrl
`default_nettype wire

// >>> rtl/zpa_map.svh
`ifndef ZPA_MAP_SVH
`define ZPA_MAP_SVH
// line framing and command letters
`define ZPA_CH_CR        8'h0D
`define ZPA_CH_LF        8'h0A
`define ZPA_CH_SPACE     8'h20
`define ZPA_CH_0         8'h30
`define ZPA_CH_9         8'h39
`define ZPA_CH_AT        8'h40
`define ZPA_CMD_FINE     8'h46
`define ZPA_CMD_FRESH    8'h47
`define ZPA_CMD_NITRO    8'h55
`define ZPA_CMD_MANUAL   8'h75
`define ZPA_CMD_KNOWN    8'h58
`define ZPA_CMD_PARAM    8'h50
`define ZPA_CMD_MULT     8'h2E
// parameter indices of the P command
`define ZPA_PIDX_BG_HI   16'h0008
`define ZPA_PIDX_BG_LO   16'h0009
`define ZPA_PIDX_FA_HI   16'h000A
`define ZPA_PIDX_FA_LO   16'h000B
// reset values and the two multiplier values
`define ZPA_ZERO_RESET   16'h7FFF
`define ZPA_CONC_RESET   16'h0190
`define ZPA_MULT_LOW     16'h000A
`define ZPA_MULT_HIGH    16'h0064
// echo buffer
`define ZPA_LINE_MAX     5'h10
// register byte offsets
`define ZPA_REG_CTRL     8'h00
`define ZPA_REG_MEAS     8'h04
`define ZPA_REG_ZERO     8'h08
`define ZPA_REG_FRESH    8'h0C
`define ZPA_REG_BKGND    8'h10
`define ZPA_REG_AZCFG    8'h14
`define ZPA_REG_STATUS   8'h18
// control bit positions
`define ZPA_CTRL_SLEEP   0
`define ZPA_CTRL_WIDE    1
// bus responses
`define ZPA_RESP_OKAY    2'h0
`define ZPA_RESP_SLVERR  2'h2
`endif

// >>> rtl/zpa_pkg.sv
package zpa_pkg;
  // one decoded command line
  typedef struct packed {
    logic [7:0]  letter;
    logic [1:0]  nargs;
    logic [15:0] arg0;
    logic [15:0] arg1;
  } zpa_line_t;

  typedef enum logic {ZPA_TX_IDLE, ZPA_TX_SEND} zpa_tx_state_t;
endpackage : zpa_pkg

// >>> rtl/zpa_line_parser.sv
`timescale 1ns/1ps
`default_nettype none
`include "zpa_map.svh"
module zpa_line_parser (
  // clock and reset
  input  wire logic             clk_sys,
  input  wire logic             rst,
  // received bytes
  input  wire logic             rxValid,
  input  wire logic [7:0]       rxData,
  // decoded line
  output logic                  lineDone,
  output zpa_pkg::zpa_line_t    lineOut
);
  import zpa_pkg::*;

  logic        firstQ;
  logic        sawCrQ;
  logic        inNumQ;
  logic [1:0]  nargsQ;
  logic [15:0] accQ;
  logic [15:0] arg0Q;
  logic [15:0] arg1Q;
  logic [7:0]  letterQ;
  logic        isDigit;
  logic        isEnd;
  logic [1:0]  nargsInc;

  assign isDigit  = (rxData >= `ZPA_CH_0) && (rxData <= `ZPA_CH_9);
  assign isEnd    = rxValid && (rxData == `ZPA_CH_LF) && sawCrQ;
  assign nargsInc = (nargsQ == 2'h3) ? nargsQ : nargsQ + 2'h1;

  // ==========================================================
  // scanning
  // a decimal point is skipped, so "1.0" gathers as tenths
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      firstQ  <= 1'b1;
      sawCrQ  <= 1'b0;
      inNumQ  <= 1'b0;
      nargsQ  <= 2'h0;
      accQ    <= 16'h0000;
      arg0Q   <= 16'h0000;
      arg1Q   <= 16'h0000;
      letterQ <= 8'h00;
    end else if (rxValid) begin
      sawCrQ <= (rxData == `ZPA_CH_CR);
      if (isEnd) begin
        firstQ  <= 1'b1;
        inNumQ  <= 1'b0;
        nargsQ  <= 2'h0;
        accQ    <= 16'h0000;
        letterQ <= 8'h00;
      end else if (rxData == `ZPA_CH_CR) begin
        firstQ <= firstQ;
      end else if (firstQ) begin
        letterQ <= rxData;
        firstQ  <= 1'b0;
      end else if (rxData == `ZPA_CH_SPACE) begin
        if (inNumQ) begin
          if (nargsQ == 2'h0) arg0Q <= accQ;
          if (nargsQ == 2'h1) arg1Q <= accQ;
          nargsQ <= nargsInc;
          accQ   <= 16'h0000;
          inNumQ <= 1'b0;
        end
      end else if (isDigit) begin
        accQ   <= accQ * 16'h000A + {12'h000, rxData[3:0]};
        inNumQ <= 1'b1;
      end
    end
  end

  // ==========================================================
  // line output
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      lineDone <= 1'b0;
      lineOut  <= '0;
    end else begin
      lineDone <= isEnd;
      if (isEnd) begin
        lineOut.letter <= letterQ;
        lineOut.nargs  <= inNumQ ? nargsInc : nargsQ;
        lineOut.arg0   <= (inNumQ && nargsQ == 2'h0) ? accQ : arg0Q;
        lineOut.arg1   <= (inNumQ && nargsQ == 2'h1) ? accQ : arg1Q;
      end
    end
  end

  crlf_end_a : assert property (@(posedge clk_sys) disable iff (rst)
    lineDone |-> $past(rxData) == `ZPA_CH_LF && $past(sawCrQ))
    else $error("line ended without CR LF");
endmodule : zpa_line_parser
`default_nettype wire

// >>> verif/zpa_host_model.sv
`timescale 1ns/1ps
`default_nettype none
module zpa_host_model (
  // clock
  input  wire logic       clk_sys,
  // command bytes to the block
  output logic            rxValid,
  output logic [7:0]      rxData,
  // reply bytes from the block
  output logic            txReady,
  input  wire logic       txValid,
  input  wire logic [7:0] txData
);
  logic slow = 1'b0;
  initial begin
    rxValid = 1'b0;
    rxData  = 8'h00;
  end
  // a slow host drops txReady every other cycle, stalling each reply byte once
  always @(posedge clk_sys) begin
    txReady <= slow ? ~txReady : 1'b1;
  end
  // =====================================================
  // one command line out, one reply line back
  task automatic xfer(input string cmd, output string rep);
    string s;
    s   = {cmd, "\r\n"};
    rep = "";
    for (int i = 0; i < s.len(); i++) begin
      @(posedge clk_sys);
      rxValid <= 1'b1;
      rxData  <= s[i];
    end
    @(posedge clk_sys);
    rxValid <= 1'b0;
    // idle byte lane never repeats the last byte
    rxData  <= ~rxData;
    // no reply within the span reads as a refusal
    repeat (200) begin
      @(posedge clk_sys);
      if (txValid && txReady) begin
        rep = $sformatf("%s%c", rep, txData);
        if (txData == 8'h0A) break;
      end
    end
  endtask : xfer
endmodule : zpa_host_model
`default_nettype wire

// >>> verif/tb.sv
`timescale 1ns/1ps
`default_nettype none
`include "zpa_map.svh"
module tb;
  logic        clk_sys = 1'b0;
  logic        rst = 1'b1;
  logic        rxValid, txValid, txReady, autoZeroOn;
  logic        autoZeroEvt = 1'b0;
  logic [7:0]  rxData, txData;
  logic [7:0]  s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
  logic [3:0]  s_axi_wstrb = 4'hF;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0;
  logic        s_axi_bready = 1'b0, s_axi_arvalid = 1'b0;
  logic        s_axi_rready = 1'b0;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid;
  logic        s_axi_arready, s_axi_rvalid;
  int          n_errors = 0, n_checks = 0;
  always #12.5 clk_sys = ~clk_sys;
  zpa_zero_ctrl zpa_zero_ctrl_inst (.clk_sys, .rst, .rxValid, .rxData,
    .txValid, .txData, .txReady, .autoZeroEvt, .autoZeroOn,
    .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
    .s_axi_rready);
  zpa_host_model zpa_host_model_inst (.clk_sys, .rxValid, .rxData,
    .txReady, .txValid, .txData);
  // =====================================================
  // compares and bus cycles
  task automatic chk_v(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("ERROR t=%0t got %h expected %h", $time, got, exp);
    end
  endtask : chk_v
  task automatic chk_s(input string got, input string exp);
    n_checks++;
    if (got != exp) begin
      n_errors++;
      $display("ERROR t=%0t reply '%s' expected '%s'", $time, got, exp);
    end
  endtask : chk_s
  task automatic xs(input string cmd, input string exp);
    string r;
    zpa_host_model_inst.xfer(cmd, r);
    chk_s(r, exp == "" ? "" : {exp, "\r\n"});
  endtask : xs
  task automatic axw(input logic [7:0] a, input logic [31:0] d,
                     input logic [1:0] er);
    @(posedge clk_sys);
    s_axi_awaddr  <= a;
    s_axi_wdata   <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid  <= 1'b1;
    s_axi_bready  <= 1'b1;
    forever begin
      @(posedge clk_sys);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid) break;
    end
    s_axi_bready <= 1'b0;
    chk_v(s_axi_bresp, er);
  endtask : axw
  task automatic axr(input logic [7:0] a, input logic [31:0] exp,
                     input logic [1:0] er);
    @(posedge clk_sys);
    s_axi_araddr  <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready  <= 1'b1;
    forever begin
      @(posedge clk_sys);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid) break;
    end
    s_axi_rready <= 1'b0;
    chk_v(s_axi_rdata, exp);
    chk_v(s_axi_rresp, er);
  endtask : axr
  // =====================================================
  // scenarios
  task automatic t_reset;
    chk_v(autoZeroOn, 0);
    axr(`ZPA_REG_ZERO, 32'h7FFF, `ZPA_RESP_OKAY);
    axr(`ZPA_REG_AZCFG, 32'h0, `ZPA_RESP_OKAY);
    xs("@", "@ 0");
    xs(".", ". 00010");
    $display("t_reset done");
  endtask : t_reset
  task automatic t_zero;
    axw(`ZPA_REG_MEAS, 32'h32, `ZPA_RESP_OKAY);
    xs("u 100", "u 00100");
    axr(`ZPA_REG_ZERO, 32'h64, `ZPA_RESP_OKAY);
    xs("U", "U 00150");
    xs("P 10 0", "P 00010 00000");
    xs("P 11 60", "P 00011 00060");
    axr(`ZPA_REG_FRESH, 32'h3C, `ZPA_RESP_OKAY);
    xs("G", "G 00140");
    xs("X 20", "X 00170");
    zpa_host_model_inst.slow = 1'b1;
    xs("F 30 10", "F 00190");
    zpa_host_model_inst.slow = 1'b0;
    $display("t_zero done");
  endtask : t_zero
  task automatic t_auto;
    xs("P 8 0", "P 00008 00000");
    xs("P 9 30", "P 00009 00030");
    axr(`ZPA_REG_BKGND, 32'h1E, `ZPA_RESP_OKAY);
    xs("@ 1.0 8.0", "@ 1.0 8.0");
    chk_v(autoZeroOn, 1);
    axr(`ZPA_REG_AZCFG, 32'h000A0050, `ZPA_RESP_OKAY);
    xs("@", "@ 1.0 8.0");
    @(posedge clk_sys);
    autoZeroEvt <= 1'b1;
    @(posedge clk_sys);
    autoZeroEvt <= 1'b0;
    axr(`ZPA_REG_ZERO, 32'hD2, `ZPA_RESP_OKAY);
    xs("@ 0", "@ 0");
    chk_v(autoZeroOn, 0);
    $display("t_auto done");
  endtask : t_auto
  task automatic t_sleep;
    axw(`ZPA_REG_CTRL, 32'h1, `ZPA_RESP_OKAY);
    xs("u 5", "");
    axr(`ZPA_REG_ZERO, 32'hD2, `ZPA_RESP_OKAY);
    axr(`ZPA_REG_STATUS, 32'h100, `ZPA_RESP_OKAY);
    xs("@", "@ 0");
    axw(`ZPA_REG_CTRL, 32'h3, `ZPA_RESP_OKAY);
    axr(`ZPA_REG_CTRL, 32'h3, `ZPA_RESP_OKAY);
    xs(".", ". 00100");
    axw(`ZPA_REG_CTRL, 32'h0, `ZPA_RESP_OKAY);
    axw(`ZPA_REG_ZERO, 32'h5, `ZPA_RESP_OKAY);
    axr(`ZPA_REG_ZERO, 32'hD2, `ZPA_RESP_OKAY);
    axw(8'h1C, 32'h1, `ZPA_RESP_SLVERR);
    axr(8'h1C, 32'h0, `ZPA_RESP_SLVERR);
    $display("t_sleep done");
  endtask : t_sleep
  task automatic end_of_test;
    $display("checks %0d errors %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : end_of_test
  initial begin
    repeat (3) @(posedge clk_sys);
    rst <= 1'b0;
    t_reset();
    t_zero();
    t_auto();
    t_sleep();
    end_of_test();
  end
  // the whole run needs well under a third of this span
  initial begin
    repeat (30000) @(posedge clk_sys);
    n_errors++;
    end_of_test();
  end
endmodule : tb
`default_nettype wire
